//--- hdl/bbcca_pkg.sv
package bbcca_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [9:0] IDX_EN6 = 10'h10a;
	localparam logic [9:0] IDX_EN7 = 10'h10b;
	localparam logic [9:0] IDX_TXCMP = 10'h116;
	localparam logic [9:0] IDX_MODE = 10'h118;
	localparam logic [9:0] IDX_FLAGS = 10'h140;
	localparam logic [9:0] IDX_STAT = 10'h141;
	// Reset values
	localparam logic [7:0] EN_RST = 8'h00;
	localparam logic [11:0] TXCMP_RST = 12'h010;
	localparam logic [4:0] MODE_RST = 5'h00;
	// Field layout
	localparam int unsigned TXCMP_W = 12;
	localparam int unsigned MODE_W = 5;
	localparam int unsigned FLAG_W = 16;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Decision rules
	typedef enum logic [1:0] {
		RULE_POWER = 2'h0,
		RULE_CARRIER = 2'h1,
		RULE_OR = 2'h2,
		RULE_AND = 2'h3
	} bbcca_rule_e;
	// Assessment mode register fields, bit 4 down to bit 0
	typedef struct packed {
		logic mid_assess_rx_en;
		logic continue_mode_sel;
		logic continue_en;
		bbcca_rule_e assess_rule;
	} bbcca_mode_s;
	// Receive side event pulses, in enable-seven bit order
	typedef struct packed {
		logic rx_level;
		logic rx_done;
		logic len_addr_filter;
		logic rx_start;
		logic rx_overrun;
		logic rx_count;
		logic rx_bank1;
		logic rx_bank0;
	} bbcca_rx_evt_s;
	// Assessment sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ASSESS = 3'h2,
		ST_MIDRX = 3'h4
	} bbcca_state_e;
endpackage

//--- hdl/bbcca_top.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module bbcca_top #(
	parameter int unsigned AXI_AW = 12,
	parameter int unsigned PWR_W = 8,
	parameter int unsigned REP_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire bbcca_pkg::bbcca_rx_evt_s rx_evt,
	input wire logic backoff_done,
	input wire logic tx_active,
	input wire logic tx_byte_moved,
	input wire logic assess_start,
	input wire logic comm_stop,
	input wire logic power_valid,
	input wire logic [PWR_W-1:0] power_level,
	input wire logic [PWR_W-1:0] energy_threshold,
	input wire logic carrier_sense,
	input wire logic signal_detect,
	input wire logic [REP_W-1:0] repeat_limit,
	input wire logic rx_cancel,
	input wire logic rx_finish,
	output logic irq_output_zero,
	output logic tx_byte_irq,
	output logic assess_busy,
	output logic rx_begin,
	output logic judge_result,
	output logic [PWR_W-1:0] energy_detect_one,
	output logic [PWR_W-1:0] energy_detect_two
);
	import bbcca_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	if (AXI_AW < 12 || AXI_AW > 32)
	begin : g_bad_aw
		$error("address width must hold word index 0x141");
	end
	if (PWR_W < 1 || PWR_W > 16 || REP_W < 1 || REP_W > 16)
	begin : g_bad_w
		$error("power and repeat widths must be 1 to 16");
	end

	// Word index of a byte address
	function automatic logic [9:0] word_idx(input logic [AXI_AW-1:0] a);
		word_idx = a[11:2];
	endfunction

	// Index is one of the mapped registers
	function automatic logic idx_mapped(input logic [9:0] i);
		idx_mapped = (i == IDX_EN6) || (i == IDX_EN7) || (i == IDX_TXCMP)
			|| (i == IDX_MODE) || (i == IDX_FLAGS) || (i == IDX_STAT);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Registers and state
	logic [7:0] en6_ff;
	logic [7:0] en7_ff;
	logic [TXCMP_W-1:0] txcmp_sw_ff;
	logic [TXCMP_W-1:0] txcmp_act_ff;
	logic txcmp_pend_ff;
	logic [TXCMP_W-1:0] tx_cnt_ff;
	logic tx_fired_ff;
	bbcca_mode_s mode_ff;
	logic [FLAG_W-1:0] flags_ff;
	bbcca_state_e state_ff;
	bbcca_state_e nxt_state;
	logic [REP_W-1:0] rep_cnt_ff;
	logic [AXI_AW-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic aw_have_ff;
	logic w_have_ff;
	logic wr_go;
	logic [9:0] wr_idx;
	logic [9:0] rd_idx;
	logic [FLAG_W-1:0] flag_clr;
	logic [FLAG_W-1:0] flag_set;
	logic [FLAG_W-1:0] nxt_flags;
	logic ev_limit;
	logic ev_clear;
	logic ev_done;
	logic ev_cancel;
	logic ch_busy;
	logic pwr_busy;
	logic sample;
	logic stop_now;
	logic tx_hit;
	logic [31:0] rd_word;

	////////////////////////////////////////////////////////////////////////////////
	// Write channel capture, address and data in either order
	assign wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;
	assign wr_idx = word_idx(awaddr_ff);

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			aw_have_ff <= 1'b0;
			awaddr_ff <= '0;
			s_axi_awready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_have_ff && !(s_axi_awvalid && s_axi_awready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_have_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			w_have_ff <= 1'b0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_wready <= !w_have_ff && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			else if (wr_go)
				w_have_ff <= 1'b0;
		end
	end

	// Write response, error for an unmapped word
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			en6_ff <= EN_RST;
			en7_ff <= EN_RST;
			mode_ff <= MODE_RST;
		end
		else if (wr_go && wstrb_ff[0])
		begin
			if (wr_idx == IDX_EN6)
				en6_ff <= wdata_ff[7:0];
			if (wr_idx == IDX_EN7)
				en7_ff <= wdata_ff[7:0];
			if (wr_idx == IDX_MODE)
				mode_ff <= wdata_ff[MODE_W-1:0];
		end
	end

	// Compare value: software copy and the copy in use
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			txcmp_sw_ff <= TXCMP_RST;
			txcmp_act_ff <= TXCMP_RST;
			txcmp_pend_ff <= 1'b0;
		end
		else
		begin
			if (wr_go && wr_idx == IDX_TXCMP && (wstrb_ff[0] || wstrb_ff[1]))
			begin
				if (wstrb_ff[0])
					txcmp_sw_ff[7:0] <= wdata_ff[7:0];
				if (wstrb_ff[1])
					txcmp_sw_ff[TXCMP_W-1:8] <= wdata_ff[TXCMP_W-1:8];
				txcmp_pend_ff <= 1'b1;
			end
			else if (txcmp_pend_ff && (!tx_active || tx_hit || tx_fired_ff))
			begin
				txcmp_act_ff <= txcmp_sw_ff;
				txcmp_pend_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit byte counting
	assign tx_hit = tx_active && tx_byte_moved && !tx_fired_ff
		&& (tx_cnt_ff + 12'h001 == txcmp_act_ff);

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !tx_active)
		begin
			tx_cnt_ff <= '0;
			tx_fired_ff <= 1'b0;
			tx_byte_irq <= 1'b0;
		end
		else
		begin
			tx_byte_irq <= tx_hit;
			if (tx_byte_moved)
				tx_cnt_ff <= tx_cnt_ff + 12'h001;
			if (tx_hit)
				tx_fired_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel decision
	assign sample = (state_ff == ST_ASSESS) && power_valid;
	assign pwr_busy = power_level >= energy_threshold;

	always_comb
	begin
		case (mode_ff.assess_rule)
			RULE_POWER: ch_busy = pwr_busy;
			RULE_CARRIER: ch_busy = carrier_sense;
			RULE_OR: ch_busy = pwr_busy || carrier_sense;
			RULE_AND: ch_busy = pwr_busy && carrier_sense;
			default: ch_busy = pwr_busy;
		endcase
	end

	// Assessment events
	assign stop_now = (state_ff == ST_ASSESS) && comm_stop;
	assign ev_clear = sample && !ch_busy && !comm_stop;
	assign ev_limit = sample && ch_busy && !comm_stop && mode_ff.continue_en
		&& mode_ff.continue_mode_sel && (rep_cnt_ff + 1'b1 >= repeat_limit);
	assign ev_cancel = (state_ff == ST_MIDRX) && rx_cancel;

	always_comb
	begin
		nxt_state = state_ff;
		ev_done = 1'b0;
		case (state_ff)
			ST_IDLE:
				if (assess_start)
					nxt_state = ST_ASSESS;
			ST_ASSESS:
				if (stop_now)
					nxt_state = ST_IDLE;
				else if (mode_ff.mid_assess_rx_en && signal_detect)
				begin
					nxt_state = ST_MIDRX;
					ev_done = 1'b1;
				end
				else if (sample && (!mode_ff.continue_en || ev_clear || ev_limit))
				begin
					nxt_state = ST_IDLE;
					ev_done = 1'b1;
				end
			ST_MIDRX:
				if (rx_cancel || rx_finish)
					nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// Sequencer and repetition count
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_IDLE;
			rep_cnt_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (state_ff != ST_ASSESS)
				rep_cnt_ff <= '0;
			else if (sample && rep_cnt_ff != {REP_W{1'b1}})
				rep_cnt_ff <= rep_cnt_ff + 1'b1;
		end
	end

	// Results refreshed on every power sample, energy_detect_two only on the first sample or a new peak
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			judge_result <= 1'b0;
			energy_detect_one <= '0;
			energy_detect_two <= '0;
		end
		else if (sample)
		begin
			judge_result <= ch_busy;
			energy_detect_one <= power_level;
			if (rep_cnt_ff == '0 || power_level > energy_detect_two)
				energy_detect_two <= power_level;
		end
	end

	// Status outputs
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			assess_busy <= 1'b0;
			rx_begin <= 1'b0;
		end
		else
		begin
			assess_busy <= (nxt_state == ST_ASSESS);
			rx_begin <= (state_ff == ST_ASSESS) && (nxt_state == ST_MIDRX);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Source flags, set wins over a write-one clear
	assign flag_set[7:0] = en6_ff & {rx_evt.rx_level, rx_evt.rx_done, rx_evt.len_addr_filter,
		rx_evt.rx_start, ev_limit, ev_clear || ev_cancel, ev_done, backoff_done};
	assign flag_set[15:8] = en7_ff & rx_evt;
	assign flag_clr = (wr_go && wr_idx == IDX_FLAGS) ? wdata_ff[FLAG_W-1:0]
		& {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}} : '0;
	assign nxt_flags = (flags_ff & ~flag_clr) | flag_set;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			flags_ff <= '0;
			irq_output_zero <= 1'b0;
		end
		else
		begin
			flags_ff <= nxt_flags;
			irq_output_zero <= |nxt_flags;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel
	assign rd_idx = word_idx(s_axi_araddr);

	always_comb
	begin
		rd_word = '0;
		case (rd_idx)
			IDX_EN6: rd_word[7:0] = en6_ff;
			IDX_EN7: rd_word[7:0] = en7_ff;
			IDX_TXCMP: rd_word[TXCMP_W-1:0] = txcmp_sw_ff;
			IDX_MODE: rd_word[MODE_W-1:0] = mode_ff;
			IDX_FLAGS: rd_word[FLAG_W-1:0] = flags_ff;
			IDX_STAT: rd_word = {8'h00, 8'(rep_cnt_ff), 13'h0000, judge_result,
				state_ff == ST_MIDRX, state_ff == ST_ASSESS};
			default: rd_word = '0;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // bbcca_top
`default_nettype wire

//--- test/bbcca_chk.sv
`timescale 1ns/1ns
`default_nettype none
module bbcca_chk #(
	parameter int unsigned PWR_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic assess_start,
	input wire logic assess_busy,
	input wire logic comm_stop,
	input wire logic power_valid,
	input wire logic [PWR_W-1:0] power_level,
	input wire logic signal_detect,
	input wire logic tx_active,
	input wire logic tx_byte_irq,
	input wire logic rx_begin,
	input wire logic [PWR_W-1:0] energy_detect_one,
	input wire logic [PWR_W-1:0] energy_detect_two
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////
	// Assessment entry, stop and results
	property p_busy_start;
		$rose(assess_busy) |-> $past(assess_start);
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy without start");
	property p_stop;
		assess_busy && comm_stop |=> !assess_busy;
	endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_ed1;
		assess_busy && power_valid |=> energy_detect_one == $past(power_level);
	endproperty
	a_ed1: assert property (p_ed1) else $error("sample not kept");
	property p_ed2;
		assess_busy && power_valid |=> energy_detect_two >= $past(power_level);
	endproperty
	a_ed2: assert property (p_ed2) else $error("peak below sample");
	// Entry into frame reception
	property p_rxb;
		rx_begin |-> $past(signal_detect) && !assess_busy;
	endproperty
	a_rxb: assert property (p_rxb) else $error("reception entry without signal");
	property p_rxb_pulse;
		rx_begin |=> !rx_begin;
	endproperty
	a_rxb_pulse: assert property (p_rxb_pulse) else $error("entry pulse too long");
	// Transmit byte request
	property p_tx_pulse;
		tx_byte_irq |=> !tx_byte_irq [*2];
	endproperty
	a_tx_pulse: assert property (p_tx_pulse) else $error("byte request repeated");
	property p_tx_cause;
		tx_byte_irq |-> $past(tx_active);
	endproperty
	a_tx_cause: assert property (p_tx_cause) else $error("byte request while idle");
	c_stop: cover property (assess_busy && comm_stop);
	c_rxb: cover property (rx_begin);
	c_tx: cover property (tx_byte_irq);
endmodule // bbcca_chk
////////////////////////////////////////////////
bind bbcca_top bbcca_chk #(.PWR_W(PWR_W)) u_bbcca_chk (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.assess_start(assess_start),
	.assess_busy(assess_busy),
	.comm_stop(comm_stop),
	.power_valid(power_valid),
	.power_level(power_level),
	.signal_detect(signal_detect),
	.tx_active(tx_active),
	.tx_byte_irq(tx_byte_irq),
	.rx_begin(rx_begin),
	.energy_detect_one(energy_detect_one),
	.energy_detect_two(energy_detect_two)
);
`default_nettype wire

//--- test/bbcca_bench.sv
`timescale 1ns/1ns
`default_nettype none
module bbcca_bench;
	import bbcca_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [31:0] wd = 32'h0, rdat, f;
	logic awr, wr_r, bv, arr, rv, irq, txirq, busy, rxb, judge;
	logic [1:0] bresp, rresp, rs, bs;
	logic [7:0] ed1, ed2, pwr = 8'h00;
	bbcca_rx_evt_s evt = '0;
	logic bko = 1'b0, txa = 1'b0, mov = 1'b0, st = 1'b0, stp = 1'b0, pv = 1'b0;
	logic sd = 1'b0, cnc = 1'b0, cs = 1'b0, fin = 1'b0;
	int err_count = 0, check_count = 0, tx_hits = 0;
	// Clock and transmit request monitor
	initial forever #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (txirq === 1'b1) tx_hits <= tx_hits + 1;
	bbcca_top u_bbcca_top (.sys_clk(sys_clk), .rst_n(rst_n),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.rx_evt(evt), .backoff_done(bko), .tx_active(txa), .tx_byte_moved(mov),
		.assess_start(st), .comm_stop(stp), .power_valid(pv), .power_level(pwr),
		.energy_threshold(8'h40), .carrier_sense(cs), .signal_detect(sd),
		.repeat_limit(8'h03), .rx_cancel(cnc), .rx_finish(fin),
		.irq_output_zero(irq), .tx_byte_irq(txirq), .assess_busy(busy), .rx_begin(rxb),
		.judge_result(judge), .energy_detect_one(ed1), .energy_detect_two(ed2));
	////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic to;
		err_count++;
		$display("wait ran out at %0t", $time);
		final_report;
	endtask
	// Bus write, both channels offered together
	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		int n;
		awa <= {i, 2'h0};
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge sys_clk);
			if (awr === 1'b1)
				awv <= 1'b0;
			if (wr_r === 1'b1)
				wv <= 1'b0;
			if (bv === 1'b1)
			begin
				bs = bresp;
				break;
			end
		end
		br <= 1'b0;
		if (n == 64)
			to();
		// One idle edge so a following call never re-raises bready in this step
		@(posedge sys_clk);
	endtask
	// Bus read into f and rs
	task automatic rd(input logic [9:0] i);
		int n;
		ara <= {i, 2'h0};
		arv <= 1'b1;
		rr <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge sys_clk);
			if (arr === 1'b1)
				arv <= 1'b0;
			if (rv === 1'b1)
				break;
		end
		f = rdat;
		rs = rresp;
		rr <= 1'b0;
		if (n == 64)
			to();
		// One idle edge so a following call never re-raises rready in this step
		@(posedge sys_clk);
	endtask
	task automatic go;
		st <= 1'b1;
		tk(1);
		st <= 1'b0;
	endtask
	task automatic smp(input logic [7:0] p);
		pwr <= p;
		pv <= 1'b1;
		tk(1);
		pv <= 1'b0;
		tk(1);
	endtask
	task automatic mv(input int n);
		repeat (n)
		begin
			mov <= 1'b1;
			tk(1);
			mov <= 1'b0;
			tk(1);
		end
	endtask
	////////////////////////////////////////////////
	task automatic t_reset;
		rd(IDX_EN6);
		chk(f, 32'h0);
		rd(IDX_EN7);
		chk(f, 32'h0);
		rd(IDX_TXCMP);
		chk(f, 32'h10);
		rd(IDX_MODE);
		chk(f, 32'h0);
		rd(10'h000);
		chk(32'(rs), 32'(RESP_SLVERR));
		wr(10'h000, 32'hffff);
		chk(32'(bs), 32'(RESP_SLVERR));
		wr(IDX_MODE, 32'h13);
		rd(IDX_MODE);
		chk(f, 32'h13);
		wr(IDX_MODE, 32'h0c);
		rd(IDX_MODE);
		chk(f, 32'h0c);
		wr(IDX_TXCMP, 32'h0abc);
		chk(32'(bs), 32'(RESP_OKAY));
		rd(IDX_TXCMP);
		chk(f, 32'h0abc);
		$display("test reset and registers done");
	endtask
	task automatic t_flags;
		wr(IDX_EN6, 32'hf0);
		wr(IDX_EN7, 32'hff);
		for (int i = 0; i < 8; i++)
		begin
			evt <= bbcca_rx_evt_s'(8'h01 << i);
			tk(1);
			evt <= '0;
			tk(1);
			rd(IDX_FLAGS);
			chk(f, (32'h100 << i) | ((i >= 4) ? (32'h1 << i) : 32'h0));
			wr(IDX_FLAGS, 32'hffff);
		end
		wr(IDX_EN6, 32'h0);
		bko <= 1'b1;
		tk(1);
		bko <= 1'b0;
		tk(1);
		rd(IDX_FLAGS);
		chk(f, 32'h0);
		chk(irq, 32'h0);
		wr(IDX_EN6, 32'h01);
		bko <= 1'b1;
		tk(1);
		bko <= 1'b0;
		tk(1);
		rd(IDX_FLAGS);
		chk(f, 32'h1);
		chk(irq, 32'h1);
		wr(IDX_FLAGS, 32'hffff);
		tk(2);
		chk(irq, 32'h0);
		$display("test flags done");
	endtask
	// Each rule with a loud power sample and no carrier, then a quiet sample with carrier
	task automatic t_rules;
		wr(IDX_EN6, 32'h0f);
		for (int c = 0; c < 2; c++)
		begin
			cs <= c[0];
			for (int r = 0; r < 4; r++)
			begin
				wr(IDX_MODE, r);
				go();
				smp((c == 0) ? 8'h80 : 8'h10);
				chk(judge, (((c == 0) ? 32'h5 : 32'h6) >> r) & 32'h1);
				chk(busy, 32'h0);
				rd(IDX_FLAGS);
				chk(f[1], 32'h1);
				wr(IDX_FLAGS, 32'hffff);
			end
		end
		cs <= 1'b0;
		$display("test decision rules done");
	endtask
	task automatic t_cont;
		wr(IDX_MODE, 32'h0c);
		go();
		smp(8'h80);
		smp(8'h80);
		chk(busy, 32'h1);
		smp(8'h80);
		chk(busy, 32'h0);
		rd(IDX_FLAGS);
		chk(f[3], 32'h1);
		wr(IDX_FLAGS, 32'hffff);
		wr(IDX_MODE, 32'h04);
		go();
		smp(8'h80);
		smp(8'h90);
		smp(8'h80);
		chk(busy, 32'h1);
		smp(8'h10);
		chk(busy, 32'h0);
		chk(ed1, 32'h10);
		chk(ed2, 32'h90);
		rd(IDX_FLAGS);
		chk(f[2:1], 32'h3);
		wr(IDX_FLAGS, 32'hffff);
		go();
		smp(8'h80);
		stp <= 1'b1;
		tk(1);
		stp <= 1'b0;
		tk(1);
		chk(busy, 32'h0);
		$display("test continuation done");
	endtask
	task automatic t_mid;
		wr(IDX_FLAGS, 32'hffff);
		wr(IDX_MODE, 32'h10);
		go();
		sd <= 1'b1;
		tk(1);
		sd <= 1'b0;
		tk(1);
		chk(rxb, 32'h1);
		rd(IDX_STAT);
		chk(f[1:0], 32'h2);
		rd(IDX_FLAGS);
		chk(f[1], 32'h1);
		wr(IDX_FLAGS, 32'hffff);
		cnc <= 1'b1;
		tk(1);
		cnc <= 1'b0;
		tk(1);
		rd(IDX_FLAGS);
		chk(f[2], 32'h1);
		rd(IDX_STAT);
		chk(f[1:0], 32'h0);
		// A reception that ends normally leaves no cancel flag
		wr(IDX_FLAGS, 32'hffff);
		go();
		sd <= 1'b1;
		tk(1);
		sd <= 1'b0;
		tk(1);
		fin <= 1'b1;
		tk(1);
		fin <= 1'b0;
		tk(1);
		rd(IDX_STAT);
		chk(f[1:0], 32'h0);
		rd(IDX_FLAGS);
		chk(f[2], 32'h0);
		$display("test mid reception done");
	endtask
	task automatic t_tx;
		wr(IDX_TXCMP, 32'h4);
		txa <= 1'b1;
		tk(1);
		mv(2);
		wr(IDX_TXCMP, 32'h2);
		mv(1);
		tk(2);
		chk(tx_hits, 32'h0);
		mv(1);
		tk(2);
		chk(tx_hits, 32'h1);
		txa <= 1'b0;
		tk(2);
		txa <= 1'b1;
		tk(1);
		mv(2);
		tk(2);
		chk(tx_hits, 32'h2);
		txa <= 1'b0;
		$display("test transmit count done");
	endtask
	// Main sequence
	initial
	begin
		tk(5);
		rst_n <= 1'b1;
		tk(2);
		t_reset();
		t_flags();
		t_rules();
		t_cont();
		t_mid();
		t_tx();
		final_report();
	end
endmodule // bbcca_bench
`default_nettype wire
